// >>> src/period_timer_with_scalers.sv
// Period timer with prescaler, postscaler, APB registers and interrupt
//
// Contract
// [R1] The postscale select field divides match events by its value plus one, 1:1 up to 1:16.
// [R2] The control register at index 12h reads bit 7 as zero and its other seven bits reset to zero.
// [R3] Unimplemented bits in the timer's registers read zero and ignore writes.
// [R4] Every reset loads the counter with zero and the period with all ones.
// [R5] The counter and its match act as the PWM time base of the capture/compare/PWM unit.
// [R6] The timer counts only while the run bit is set.
// [R7] The prescale select field divides the instruction clock by 1, 4 or 16.
// [R8] The counter runs from zero up to the period, then returns to zero with one match event.
// [R9] The postscaler output sets the sticky match flag, which stays until software clears it.
// [R10] Counter and control writes clear both scalers, and a control write leaves the counter alone; a prescaler tick in that cycle still moves the counter.
//
// Added by the designer: the APB interface to the registers.
module period_timer_with_scalers
  import ptimer_pkg::*;
(
  // Clock, reset, clock enable
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic        clk_en,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output      logic [31:0] prdata,
  output      logic        pready,
  output      logic        pslverr,
  // Interrupt and PWM time base
  output      logic        irq,
  output      logic [7:0]  timebase_count,
  output      logic        timebase_match
);

  logic        rst_meta_q;
  logic        rst_n_q;
  logic [6:0]  ctl_q;
  logic [7:0]  count_q;
  logic [7:0]  period_q;
  logic        flag_q;
  logic        match_ie_q;
  logic        gie_q;
  logic        peripheral_irq_gate_q;
  logic        match_q;
  logic        irq_q;
  logic        pready_q;
  logic        pslverr_q;
  logic [31:0] prdata_q;

  // Reset released through two flops
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  function automatic logic reg_hit(input logic [9:0] a, input logic [9:0] r);
    return a == r;
  endfunction

  wire [9:0] reg_idx   = paddr[11:2];
  wire       hit_ictl  = reg_hit(reg_idx, IDX_INTCTL);
  wire       hit_flags = reg_hit(reg_idx, IDX_FLAGS);
  wire       hit_cnt   = reg_hit(reg_idx, IDX_COUNT);
  wire       hit_ctl   = reg_hit(reg_idx, IDX_CTL);
  wire       hit_ien   = reg_hit(reg_idx, IDX_IEN);
  wire       hit_per   = reg_hit(reg_idx, IDX_PERIOD);
  wire       hit_any   = hit_ictl | hit_flags | hit_cnt | hit_ctl | hit_ien | hit_per;

  // One wait state: data is loaded on the same edge that raises pready
  wire acc       = psel & penable & clk_en;
  wire rd_load   = acc & ~pready_q;
  wire wr_take   = acc & pready_q & pwrite & hit_any;
  wire wr_ictl   = wr_take & hit_ictl;
  wire wr_flags  = wr_take & hit_flags;
  wire wr_cnt    = wr_take & hit_cnt;
  wire wr_ctl    = wr_take & hit_ctl;
  wire wr_ien    = wr_take & hit_ien;
  wire wr_per    = wr_take & hit_per;

  // [R3] unimplemented bits read zero
  wire [7:0] rd_byte =
    hit_ictl  ? {gie_q, peripheral_irq_gate_q, 6'h00} :
    hit_flags ? {6'h00, flag_q, 1'b0} :
    hit_cnt   ? count_q :
    hit_ctl   ? {1'b0, ctl_q} :
    hit_ien   ? {6'h00, match_ie_q, 1'b0} :
    hit_per   ? period_q : 8'h00;

  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else if (clk_en) begin
      // Pready stands through a stall, so stalls belong before the answer
      pready_q <= psel & penable & ~pready_q;
      if (rd_load) begin
        pslverr_q <= ~hit_any;
        prdata_q  <= {24'h00_0000, rd_byte};
      end
    end
  end

  // Scalers
  scaler_if sc ();
  assign sc.ce       = clk_en;
  // [R10] scaler clear on counter or control write
  assign sc.clr      = wr_ctl | wr_cnt;
  assign sc.run      = ctl_q[CTL_RUN_BIT];
  assign sc.pre_sel  = ctl_q[CTL_PRE_LSB +: 2];
  assign sc.post_sel = ctl_q[CTL_POST_LSB +: 4];
  assign sc.match    = match_q;

  timer_scalers u_scalers (
    .core_clk (core_clk),
    .rst_n    (rst_n_q),
    .sc       (sc)
  );

  // [R2] control register, seven bits
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ctl_q      <= CTL_RST;
      // [R4] period reset to all ones
      period_q   <= PERIOD_RST;
      match_ie_q <= 1'b0;
      gie_q      <= 1'b0;
      peripheral_irq_gate_q     <= 1'b0;
    end else if (clk_en) begin
      if (wr_ctl) begin
        ctl_q <= pwdata[6:0];
      end
      if (wr_per) begin
        period_q <= pwdata[7:0];
      end
      if (wr_ien) begin
        match_ie_q <= pwdata[IEN_MATCH_BIT];
      end
      if (wr_ictl) begin
        gie_q  <= pwdata[ICTL_GIE_BIT];
        peripheral_irq_gate_q <= pwdata[ICTL_PERIPHERAL_IRQ_GATE_BIT];
      end
    end
  end

  wire       at_period = (count_q == period_q);
  wire [7:0] count_inc = count_q + 8'h01;

  // [R8] count up to period, wrap with a match
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      // [R4] counter reset to zero
      count_q <= COUNT_RST;
      match_q <= 1'b0;
    end else if (clk_en) begin
      match_q <= sc.tick & at_period & ~wr_cnt;
      // Software write beats an increment in the same cycle
      if (wr_cnt) begin
        count_q <= pwdata[7:0];
      end else if (sc.tick) begin
        count_q <= at_period ? COUNT_RST : count_inc;
      end
    end
  end

  // [R9] sticky flag, set beats write-one clear
  wire flag_clr = wr_flags & pwdata[FLAG_MATCH_BIT];

  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      flag_q <= 1'b0;
      irq_q  <= 1'b0;
    end else if (clk_en) begin
      flag_q <= sc.post_out | (flag_q & ~flag_clr);
      irq_q  <= flag_q & match_ie_q & peripheral_irq_gate_q & gie_q;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign irq     = irq_q;
  // [R5] PWM time base taken from the counter
  assign timebase_count = count_q;
  assign timebase_match = match_q;

  // Checks
  sequence s_wrap_cause;
    clk_en && sc.tick && at_period && !wr_cnt;
  endsequence

  sequence s_wrap_result;
    count_q == COUNT_RST && match_q;
  endsequence

  property p_wrap;
    @(posedge core_clk) disable iff (!rst_n_q) s_wrap_cause |=> s_wrap_result;
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter did not wrap with match"); // [R8]

  property p_inc;
    @(posedge core_clk) disable iff (!rst_n_q)
      (clk_en && sc.tick && !at_period && !wr_cnt) |=> (count_q == $past(count_q) + 8'h01) && !match_q;
  endproperty
  a_inc: assert property (p_inc) else $error("counter did not increment"); // [R8]

  property p_stop;
    @(posedge core_clk) disable iff (!rst_n_q)
      (!ctl_q[CTL_RUN_BIT] && !wr_cnt) |=> $stable(count_q);
  endproperty
  a_stop: assert property (p_stop) else $error("counter moved while stopped"); // [R6]

  property p_ctl_read;
    @(posedge core_clk) disable iff (!rst_n_q)
      (rd_load && hit_ctl) |=> (prdata_q == {25'h000_0000, ctl_q}) && pready_q;
  endproperty
  a_ctl_read: assert property (p_ctl_read) else $error("control read wrong"); // [R2]

  property p_flags_read;
    @(posedge core_clk) disable iff (!rst_n_q)
      (rd_load && hit_flags) |=> (prdata_q[31:2] == 30'h0000_0000) && !prdata_q[0];
  endproperty
  a_flags_read: assert property (p_flags_read) else $error("unimplemented bits not zero"); // [R3]

  property p_reset_vals;
    @(posedge core_clk) disable iff (!rst_n_q)
      !$past(rst_n_q) |-> (count_q == COUNT_RST && period_q == PERIOD_RST && ctl_q == CTL_RST);
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong"); // [R4]

  property p_flag_sticky;
    @(posedge core_clk) disable iff (!rst_n_q)
      (flag_q && !flag_clr) || (clk_en && sc.post_out) |=> flag_q;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("match flag lost"); // [R9]

  property p_ctl_keeps_count;
    @(posedge core_clk) disable iff (!rst_n_q)
      (wr_ctl && !sc.tick) |=> $stable(count_q);
  endproperty
  a_ctl_keeps_count: assert property (p_ctl_keeps_count) else $error("control write changed counter"); // [R10]

  property p_irq_level;
    @(posedge core_clk) disable iff (!rst_n_q)
      clk_en |=> (irq_q == $past(flag_q && match_ie_q && peripheral_irq_gate_q && gie_q));
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq does not follow flag and enables"); // [R9]

  property p_flag_clear;
    @(posedge core_clk) disable iff (!rst_n_q)
      (clk_en && flag_clr && !sc.post_out) |=> !flag_q;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("match flag not cleared"); // [R9]

  property p_flag_read;
    @(posedge core_clk) disable iff (!rst_n_q)
      (rd_load && hit_flags) |=> (prdata_q[FLAG_MATCH_BIT] == $past(flag_q));
  endproperty
  a_flag_read: assert property (p_flag_read) else $error("match flag read wrong"); // [R9]

  property p_unmapped;
    @(posedge core_clk) disable iff (!rst_n_q)
      (rd_load && !hit_any) |=> pslverr_q && (prdata_q == 32'h0000_0000);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused"); // [R3]

  property p_ien_read;
    @(posedge core_clk) disable iff (!rst_n_q)
      (rd_load && hit_ien) |=> (prdata_q == {30'h0000_0000, $past(match_ie_q), 1'b0});
  endproperty
  a_ien_read: assert property (p_ien_read) else $error("enable register read wrong"); // [R3]

  property p_ictl_read;
    @(posedge core_clk) disable iff (!rst_n_q)
      (rd_load && hit_ictl) |=> (prdata_q[31:8] == 24'h00_0000) && (prdata_q[5:0] == 6'h00);
  endproperty
  a_ictl_read: assert property (p_ictl_read) else $error("interrupt control spare bits not zero"); // [R3]

  property p_count_write;
    @(posedge core_clk) disable iff (!rst_n_q)
      wr_cnt |=> (count_q == $past(pwdata[7:0])) && !match_q;
  endproperty
  a_count_write: assert property (p_count_write) else $error("counter write not taken"); // [R10]

  property p_period_write;
    @(posedge core_clk) disable iff (!rst_n_q)
      wr_per |=> (period_q == $past(pwdata[7:0]));
  endproperty
  a_period_write: assert property (p_period_write) else $error("period write not taken"); // [R8]

  property p_ctl_write;
    @(posedge core_clk) disable iff (!rst_n_q)
      wr_ctl |=> (ctl_q == $past(pwdata[6:0]));
  endproperty
  a_ctl_write: assert property (p_ctl_write) else $error("control write not taken"); // [R2]

  property p_freeze;
    @(posedge core_clk) disable iff (!rst_n_q)
      !clk_en |=> $stable(count_q) && $stable(flag_q) && $stable(ctl_q) && $stable(period_q);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while clock enable low"); // [R6]

endmodule

// >>> src/ptimer_pkg.sv
// Constants for the period timer: register indexes, fields and reset values
package ptimer_pkg;
  // Register indexes; byte address is four times the index
  localparam logic [9:0] IDX_INTCTL = 10'h00B;
  localparam logic [9:0] IDX_FLAGS  = 10'h00C;
  localparam logic [9:0] IDX_COUNT  = 10'h011;
  localparam logic [9:0] IDX_CTL    = 10'h012;
  localparam logic [9:0] IDX_IEN    = 10'h08C;
  localparam logic [9:0] IDX_PERIOD = 10'h092;
  // Field positions
  localparam int CTL_PRE_LSB    = 0;
  localparam int CTL_RUN_BIT    = 2;
  localparam int CTL_POST_LSB   = 3;
  localparam int FLAG_MATCH_BIT = 1;
  localparam int IEN_MATCH_BIT  = 1;
  localparam int ICTL_PERIPHERAL_IRQ_GATE_BIT  = 6;
  localparam int ICTL_GIE_BIT   = 7;
  // Reset values
  localparam logic [6:0] CTL_RST    = 7'h00;
  localparam logic [7:0] COUNT_RST  = 8'h00;
  localparam logic [7:0] PERIOD_RST = 8'hFF;
  // Prescaler terminal counts for 1:1, 1:4, 1:16
  localparam logic [3:0] PRE_LIM_1  = 4'h0;
  localparam logic [3:0] PRE_LIM_4  = 4'h3;
  localparam logic [3:0] PRE_LIM_16 = 4'hF;
endpackage

// >>> src/scaler_if.sv
// Signals between the timer core and its prescaler/postscaler
interface scaler_if;
  logic       ce;
  logic       clr;
  logic       run;
  logic [1:0] pre_sel;
  logic [3:0] post_sel;
  logic       match;
  logic       tick;
  logic       post_out;
  modport timer  (output ce, clr, run, pre_sel, post_sel, match, input tick, post_out);
  modport scaler (input ce, clr, run, pre_sel, post_sel, match, output tick, post_out);
endinterface

// >>> src/timer_scalers.sv
// Prescaler and postscaler counters of the period timer
module timer_scalers
  import ptimer_pkg::*;
(
  // Clock and synchronised reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Timer side
  scaler_if.scaler sc
);

  logic [3:0] pre_q;
  logic [3:0] post_q;

  function automatic logic [3:0] pre_limit(input logic [1:0] sel);
    return sel[1] ? PRE_LIM_16 : (sel[0] ? PRE_LIM_4 : PRE_LIM_1);
  endfunction

  wire [3:0] lim     = pre_limit(sc.pre_sel);
  wire       post_hit = (post_q == sc.post_sel);

  // [R7] divide by 1, 4 or 16
  assign sc.tick = sc.run & (pre_q == lim);
  // [R1] every (select+1)th match
  assign sc.post_out = sc.match & ~sc.clr & post_hit;

  // [R10] counters cleared by writes
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_q  <= 4'h0;
      post_q <= 4'h0;
    end else if (sc.ce) begin
      if (sc.clr) begin
        pre_q  <= 4'h0;
        post_q <= 4'h0;
      end else begin
        // [R6] prescaler holds while stopped
        if (sc.run) begin
          pre_q <= sc.tick ? 4'h0 : pre_q + 4'h1;
        end
        if (sc.match) begin
          post_q <= post_hit ? 4'h0 : post_q + 4'h1;
        end
      end
    end
  end

  property p_pre_stop;
    @(posedge core_clk) disable iff (!rst_n) (sc.ce && !sc.run && !sc.clr) |=> $stable(pre_q);
  endproperty
  a_pre_stop: assert property (p_pre_stop) else $error("tick while stopped"); // [R6]

  property p_pre_count;
    @(posedge core_clk) disable iff (!rst_n)
      (sc.ce && sc.run && !sc.clr && !sc.tick) |=> (pre_q == $past(pre_q) + 4'h1);
  endproperty
  a_pre_count: assert property (p_pre_count) else $error("prescaler did not advance"); // [R7]

  property p_post_fire;
    @(posedge core_clk) disable iff (!rst_n)
      (sc.ce && sc.match && !sc.clr && post_q == sc.post_sel) |-> sc.post_out ##1 (post_q == 4'h0);
  endproperty
  a_post_fire: assert property (p_post_fire) else $error("postscaler output wrong"); // [R1]

  property p_clr;
    @(posedge core_clk) disable iff (!rst_n)
      (sc.ce && sc.clr) |=> (pre_q == 4'h0 && post_q == 4'h0);
  endproperty
  a_clr: assert property (p_clr) else $error("scalers not cleared"); // [R10]

endmodule

// >>> verification/tb_top.sv
// Self-checking bench for the period timer with scalers
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ptimer_pkg::*;

  logic        core_clk = 1'b0;
  logic        rstn     = 1'b0;
  logic        clk_en   = 1'b1;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [11:0] paddr    = 12'h000;
  logic [31:0] pwdata   = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic [7:0]  timebase_count;
  logic        timebase_match;
  logic [32:0] exp_q[$];
  logic [32:0] exp_v;
  logic [31:0] d;
  logic        rnd_en     = 1'b0;
  int          num_errors = 0;
  int          n_tests    = 0;
  int          seed       = 86193;
  int          n;
  int          nm;
  int          pre_div[4] = '{1, 4, 16, 16};
  int          post_v[3]  = '{0, 1, 15};

  period_timer_with_scalers dut (
    .core_clk      (core_clk),
    .rstn          (rstn),
    .clk_en        (clk_en),
    .psel          (psel),
    .penable       (penable),
    .pwrite        (pwrite),
    .paddr         (paddr),
    .pwdata        (pwdata),
    .prdata        (prdata),
    .pready        (pready),
    .pslverr       (pslverr),
    .irq           (irq),
    .timebase_count(timebase_count),
    .timebase_match(timebase_match)
  );

  always #20 core_clk = ~core_clk;

  // Random stalls only while the timer is idle, never on the answer cycle
  always @(posedge core_clk) begin
    clk_en <= (rnd_en && !(psel && penable)) ? 1'($random(seed)) : 1'b1;
  end

  task automatic final_report;
    $display("errors %0d comparisons %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // Read answers are matched in order of issue
  always @(posedge core_clk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
      exp_v = exp_q.pop_front();
      chk({pslverr, prdata}, exp_v);
    end
  end

  task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
    int i;
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= wd;
    penable <= 1'b0;
    @(posedge core_clk);
    penable <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(posedge core_clk);
      if (pready === 1'b1) break;
    end
    if (i == 100) begin
      num_errors++;
      final_report();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic rd(input logic [9:0] idx, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, idx, 32'h0000_0000);
  endtask

  task automatic wait_match(output int c);
    c = 0;
    do begin
      @(posedge core_clk);
      c++;
    end while (timebase_match !== 1'b1 && c < 5000);
    if (c >= 5000) begin
      num_errors++;
      final_report();
    end
  endtask

  initial begin
    repeat (10) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge core_clk);
    rd(IDX_CTL, 33'h0_0000_0000);
    rd(IDX_COUNT, 33'h0_0000_0000);
    rd(IDX_PERIOD, 33'h0_0000_00FF);
    rd(IDX_FLAGS, 33'h0_0000_0000);
    rd(IDX_IEN, 33'h0_0000_0000);
    rd(IDX_INTCTL, 33'h0_0000_0000);
    apb(1'b1, IDX_CTL, 32'hFFFF_FFF8);
    rd(IDX_CTL, 33'h0_0000_0078);
    rd(10'h3FF, 33'h1_0000_0000);
    rnd_en <= 1'b1;
    for (int k = 0; k < 6; k++) begin
      d = $random(seed);
      apb(1'b1, IDX_PERIOD, d);
      rd(IDX_PERIOD, {25'h0, d[7:0]});
    end
    rnd_en <= 1'b0;
    apb(1'b1, IDX_COUNT, 32'h0000_0005);
    apb(1'b1, IDX_CTL, 32'h0000_0003);
    repeat (40) @(posedge core_clk);
    rd(IDX_COUNT, 33'h0_0000_0005);
    chk({25'h0, timebase_count}, 33'h0_0000_0005);
    apb(1'b1, IDX_PERIOD, 32'h0000_0003);
    apb(1'b1, IDX_COUNT, 32'h0000_0000);
    for (int p = 0; p < 4; p++) begin
      apb(1'b1, IDX_CTL, 32'(4 + p));
      wait_match(n);
      wait_match(n);
      chk(33'(n), 33'(4 * pre_div[p]));
    end
    apb(1'b1, IDX_IEN, 32'h0000_0002);
    apb(1'b1, IDX_INTCTL, 32'h0000_00C0);
    rd(IDX_INTCTL, 33'h0_0000_00C0);
    for (int j = 0; j < 3; j++) begin
      apb(1'b1, IDX_CTL, 32'h0000_0000);
      apb(1'b1, IDX_FLAGS, 32'h0000_0002);
      apb(1'b1, IDX_COUNT, 32'h0000_0000);
      apb(1'b1, IDX_CTL, 32'((post_v[j] << 3) | 4));
      nm = 0;
      for (int i = 0; i < 3000 && irq !== 1'b1; i++) begin
        @(posedge core_clk);
        if (timebase_match === 1'b1) nm++;
      end
      if (irq !== 1'b1) begin
        num_errors++;
        final_report();
      end
      chk(33'(nm), 33'(post_v[j] + 1));
      apb(1'b1, IDX_CTL, 32'h0000_0000);
      repeat (10) @(posedge core_clk);
      chk({32'h0, irq}, 33'h1);
      rd(IDX_FLAGS, 33'h0_0000_0002);
    end
    apb(1'b1, IDX_IEN, 32'h0000_0000);
    repeat (3) @(posedge core_clk);
    chk({32'h0, irq}, 33'h0);
    apb(1'b1, IDX_IEN, 32'h0000_0002);
    repeat (3) @(posedge core_clk);
    chk({32'h0, irq}, 33'h1);
    apb(1'b1, IDX_FLAGS, 32'h0000_0002);
    repeat (3) @(posedge core_clk);
    chk({32'h0, irq}, 33'h0);
    rd(IDX_FLAGS, 33'h0_0000_0000);
    apb(1'b1, IDX_PERIOD, 32'h0000_0021);
    apb(1'b1, IDX_COUNT, 32'h0000_0012);
    apb(1'b1, IDX_CTL, 32'h0000_007F);
    rstn <= 1'b0;
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge core_clk);
    rd(IDX_COUNT, 33'h0_0000_0000);
    rd(IDX_PERIOD, 33'h0_0000_00FF);
    rd(IDX_CTL, 33'h0_0000_0000);
    chk({32'h0, irq}, 33'h0);
    final_report();
  end
endmodule
